/* File: uer_defs.svh */
`ifndef UER_DEFS_SVH
`define UER_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses on the peripheral bus)
// ****************************************************************
`define UER_OFS_DATA     12'h000
`define UER_OFS_STATUS   12'h004
`define UER_OFS_LCTRL    12'h02C

// ****************************************************************
// field positions
// ****************************************************************
`define UER_DR_OE_BIT    11
`define UER_DR_BE_BIT    10
`define UER_DR_PE_BIT    9
`define UER_DR_FE_BIT    8
`define UER_LC_PEN_BIT   1
`define UER_LC_EPS_BIT   2
`define UER_LC_FEN_BIT   4
`define UER_LC_SPS_BIT   7

// ****************************************************************
// reset values
// ****************************************************************
`define UER_STATUS_RST   4'h0
`define UER_LCTRL_RST    4'h0

// ****************************************************************
// timing: 16 baud ticks per bit, sampled mid-bit
// ****************************************************************
`define UER_TICK_MID     4'h7
`define UER_TICK_LAST    4'hF
`define UER_LAST_DBIT    3'h7
`define UER_FIFO_DEPTH   32

`endif

/* File: uer_pkg.sv */
package uer_pkg;

  // one received character with its error flags
  typedef struct packed {
    logic       brk;
    logic       par_err;
    logic       frm_err;
    logic [7:0] data;
  } uer_rxw_t;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP,
    RX_BREAK
  } uer_rx_state_t;

endpackage : uer_pkg

/* File: uer_rx_error_status.sv */
// What this block does
// - set data-view overrun bit when a character completes with FIFO full
// - on overrun the newly received character is dropped, not written
// - on overrun FIFO entries are kept; only the shifter is overwritten
// - data-view overrun bit clears once the FIFO has room again
// - flag break when line is low for a full character incl. stop bit
// - a break puts exactly one all-zero character into the FIFO
// - after break wait for line high and a new valid start bit
// - flag parity error when parity bit disagrees with control bits 2 and 7
// - flag framing error when the stop-position sample is not 1
// - break, parity, framing flags in data view belong to FIFO head
// - data low byte reads received character; writes queue a transmit byte
// - any write to error clear clears all four status flags, except overrun if an overrun occurs that cycle
// - status and error clear share one address; read status, write clears
// - status break/parity/framing load only on data read, for that character
// - status overrun bit sets at the moment of overrun
// - the value written to error clear is ignored
`timescale 1ns/1ps
`include "uer_defs.svh"

// ****************************************************************
// receive buffer
// ****************************************************************
module uer_fifo #(
  parameter int W = 11,
  parameter int D = `UER_FIFO_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 ce,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D):0]        count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire           do_push = ce & in_valid & in_ready;
  wire           do_pop  = ce & out_valid & out_ready;

  assign in_ready  = (count != D[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)  rd_ptr <= rd_ptr + 1'b1;
      if (do_push != do_pop) begin
        count <= do_push ? count + 1'b1 : count - 1'b1;
      end
    end
  end
endmodule : uer_fifo

// ****************************************************************
// receiver, error flags and register slave
// ****************************************************************
module uer_rx_error_status (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        baud_tick,
  input  wire logic        rx_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [7:0]       tx_data,
  output logic             tx_push
);
  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  logic rx_meta;
  logic rxd;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_meta <= 1'b1;
      rxd     <= 1'b1;
    end else if (ce) begin
      rx_meta <= rx_in;
      rxd     <= rx_meta;
    end
  end

  // ****************************************************************
  // line control
  // ****************************************************************
  logic [3:0] lctrl;  // {sps, fen, eps, pen}
  wire pen = lctrl[0];
  wire eps = lctrl[1];
  wire fen = lctrl[2];
  wire sps = lctrl[3];

  function automatic logic parity_bad(input logic [7:0] d, input logic p,
                                      input logic e, input logic s);
    logic expect_bit;
    expect_bit = s ? ~e : (e ? ^d : ~^d);
    return p != expect_bit;
  endfunction : parity_bad

  // ****************************************************************
  // receive state machine
  // ****************************************************************
  uer_pkg::uer_rx_state_t state;
  logic [3:0] tcnt;
  logic [2:0] bcnt;
  logic [7:0] shift;
  logic       pbit;

  wire tick_mid  = baud_tick & (tcnt == `UER_TICK_MID);
  wire tick_last = baud_tick & (tcnt == `UER_TICK_LAST);
  wire finish    = (state == uer_pkg::RX_STOP) & tick_last;
  // all-zero frame with low stop sample: line low for a full character
  wire is_break  = (shift == 8'h00) & ~pbit & ~rxd;

  uer_pkg::uer_rxw_t rx_word;
  assign rx_word.brk     = is_break;
  assign rx_word.par_err = pen & parity_bad(shift, pbit, eps, sps);
  assign rx_word.frm_err = ~rxd;
  assign rx_word.data    = shift;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= uer_pkg::RX_IDLE;
      tcnt  <= 4'h0;
      bcnt  <= 3'h0;
      shift <= 8'h00;
      pbit  <= 1'b0;
    end else if (ce) begin
      if (baud_tick) tcnt <= tcnt + 4'h1;
      unique case (state)
        uer_pkg::RX_IDLE: begin
          tcnt <= 4'h0;
          if (!rxd) state <= uer_pkg::RX_START;
        end
        uer_pkg::RX_START: begin
          if (tick_mid) begin
            tcnt  <= 4'h0;
            bcnt  <= 3'h0;
            pbit  <= 1'b0;
            state <= rxd ? uer_pkg::RX_IDLE : uer_pkg::RX_DATA;
          end
        end
        uer_pkg::RX_DATA: begin
          if (tick_last) begin
            shift <= {rxd, shift[7:1]};
            bcnt  <= bcnt + 3'h1;
            if (bcnt == `UER_LAST_DBIT) begin
              state <= pen ? uer_pkg::RX_PARITY : uer_pkg::RX_STOP;
            end
          end
        end
        uer_pkg::RX_PARITY: begin
          if (tick_last) begin
            pbit  <= rxd;
            state <= uer_pkg::RX_STOP;
          end
        end
        uer_pkg::RX_STOP: begin
          // one zero character per break, then hold off until marking
          if (tick_last) begin
            state <= is_break ? uer_pkg::RX_BREAK : uer_pkg::RX_IDLE;
          end
        end
        uer_pkg::RX_BREAK: begin
          if (rxd) state <= uer_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // receive buffer and overrun
  // ****************************************************************
  logic                 fifo_in_ready;
  logic                 head_valid;
  uer_pkg::uer_rxw_t    head;
  logic [5:0]           fifo_count;
  logic                 rd_pop;

  // without FIFO mode the buffer acts as a one-entry holding register
  wire full_eff = fen ? ~fifo_in_ready : (fifo_count != 6'h00);
  wire ovr_evt  = finish & full_eff;
  wire push     = finish & ~full_eff;

  uer_fifo #(
    .W ($bits(uer_pkg::uer_rxw_t)),
    .D (`UER_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_word),
    .out_valid (head_valid),
    .out_ready (rd_pop),
    .out_data  (head),
    .count     (fifo_count)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire sel_dr   = (paddr == `UER_OFS_DATA);
  wire sel_rs   = (paddr == `UER_OFS_STATUS);
  wire sel_lc   = (paddr == `UER_OFS_LCTRL);
  wire mapped   = sel_dr | sel_rs | sel_lc;
  wire wr_dr    = access & pwrite & sel_dr;
  wire wr_rs    = access & pwrite & sel_rs;
  wire wr_lc    = access & pwrite & sel_lc;
  logic rd_ok;  // head was valid when prdata was captured
  assign rd_pop = access & ~pwrite & sel_dr & rd_ok;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // ****************************************************************
  // error flags
  // ****************************************************************
  logic       dr_ovr;
  logic       st_oe;
  logic [2:0] st_bpf;

  // set wins over clear for the overrun flags
  wire       next_dr_ovr = ovr_evt | (dr_ovr & full_eff);
  wire       next_st_oe  = ovr_evt | (st_oe & ~wr_rs);
  wire [2:0] next_st_bpf = rd_pop ? {head.brk, head.par_err, head.frm_err}
                         : (wr_rs ? 3'h0 : st_bpf);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dr_ovr <= 1'b0;
      st_oe  <= 1'b0;
      st_bpf <= 3'h0;
    end else if (ce) begin
      dr_ovr <= next_dr_ovr;
      st_oe  <= next_st_oe;
      st_bpf <= next_st_bpf;
    end
  end

  // ****************************************************************
  // read data and writes
  // ****************************************************************
  wire [31:0] dr_view = {20'h0_0000, dr_ovr, head.brk, head.par_err,
                         head.frm_err, head.data};
  wire [31:0] rs_view = {28'h000_0000, st_oe, st_bpf};
  wire [31:0] lc_view = {24'h00_0000, sps, 2'b00, fen, 1'b0, eps, pen,
                         1'b0};
  wire [31:0] next_prdata = sel_dr ? dr_view
                          : sel_rs ? rs_view
                          : sel_lc ? lc_view : 32'h0000_0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      rd_ok   <= 1'b0;
      lctrl   <= `UER_LCTRL_RST;
      tx_data <= 8'h00;
      tx_push <= 1'b0;
    end else if (ce) begin
      tx_push <= wr_dr;
      if (setup & ~pwrite) begin
        prdata <= next_prdata;
        rd_ok  <= head_valid;
      end
      if (wr_dr) tx_data <= pwdata[7:0];
      if (wr_lc) begin
        lctrl <= {pwdata[`UER_LC_SPS_BIT], pwdata[`UER_LC_FEN_BIT],
                  pwdata[`UER_LC_EPS_BIT], pwdata[`UER_LC_PEN_BIT]};
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_ovr_sets;
    ce && ovr_evt |=> st_oe && dr_ovr;
  endproperty
  a_ovr_sets: assert property (p_ovr_sets)
    else $error("overrun did not set flags");

  property p_ovr_drop;
    ovr_evt |-> !push;
  endproperty
  a_ovr_drop: assert property (p_ovr_drop)
    else $error("overrun character was pushed");

  property p_ovr_keep;
    ce && ovr_evt && !rd_pop |=> $stable(fifo_count);
  endproperty
  a_ovr_keep: assert property (p_ovr_keep)
    else $error("fifo changed on overrun");

  property p_dr_ovr_clr;
    ce && dr_ovr && !full_eff && !ovr_evt |=> !dr_ovr;
  endproperty
  a_dr_ovr_clr: assert property (p_dr_ovr_clr)
    else $error("data overrun bit stuck with room");

  property p_brk_zero;
    push && rx_word.brk |-> rx_word.data == 8'h00 && rx_word.frm_err;
  endproperty
  a_brk_zero: assert property (p_brk_zero)
    else $error("break character not zero");

  property p_brk_hold;
    ce && state == uer_pkg::RX_BREAK && !rxd |=>
      state == uer_pkg::RX_BREAK && !push;
  endproperty
  a_brk_hold: assert property (p_brk_hold)
    else $error("receiver left break while low");

  property p_frm;
    push |-> rx_word.frm_err == !rxd;
  endproperty
  a_frm: assert property (p_frm)
    else $error("framing flag wrong");

  property p_clear;
    ce && wr_rs && !ovr_evt |=> pslverr == 1'b0 && st_oe == 1'b0
      && st_bpf == 3'h0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("error clear did not clear");

  property p_rd_load;
    ce && rd_pop |=> st_bpf == $past({head.brk, head.par_err, head.frm_err});
  endproperty
  a_rd_load: assert property (p_rd_load)
    else $error("status not loaded from read character");

  property p_reserved;
    prdata[31:12] == 20'h0_0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved read bits not zero");

  c_overrun: cover property (ce && ovr_evt);
  c_break:   cover property (push && rx_word.brk);
  c_parity:  cover property (push && rx_word.par_err);
  c_clear:   cover property (ce && wr_rs && st_oe);
endmodule : uer_rx_error_status

/* File: uer_tx_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// far-side serial transmitter, 16 baud ticks per bit
// ****************************************************************
module uer_tx_model (
  input  wire logic clk,
  input  wire logic baud_tick,
  output logic      rx_in
);
  initial rx_in = 1'b1;

  // counts ticks as sampled at the edge, then steps off it
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      while (baud_tick !== 1'b1) @(posedge clk);
    end
    #1;
  endtask : ticks

  task automatic send_frame(input logic [7:0] d, input logic pen,
                            input logic pbit, input logic stop_ok);
    rx_in = 1'b0;
    ticks(16);
    for (int i = 0; i < 8; i++) begin
      rx_in = d[i];
      ticks(16);
    end
    if (pen) begin
      rx_in = pbit;
      ticks(16);
    end
    // a bad stop is short, so it cannot pass for a new start bit
    rx_in = stop_ok;
    ticks(stop_ok ? 16 : 10);
    rx_in = 1'b1;
    ticks(16);
  endtask : send_frame

  task automatic hold_low(input int nbits);
    rx_in = 1'b0;
    ticks(16 * nbits);
    rx_in = 1'b1;
    ticks(32);
  endtask : hold_low
endmodule : uer_tx_model

/* File: tb_uer_rx_error_status.sv */
`timescale 1ns/1ps
`include "uer_defs.svh"
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module tb_uer_rx_error_status;
  localparam int LIMIT = 40000;
  localparam logic [7:0] MODES [4] = '{8'h16, 8'h12, 8'h96, 8'h92};
  logic        clk;
  logic        reset_n;
  logic        ce;
  logic        baud_tick;
  logic        rx_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  tx_data;
  logic        tx_push;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  lc;
  logic [7:0]  da;
  int          errors;
  int          n_tests;
  int          cyc;

  uer_rx_error_status u_dut (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .baud_tick(baud_tick),
    .rx_in    (rx_in),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .tx_data  (tx_data),
    .tx_push  (tx_push)
  );

  uer_tx_model u_tx (.clk(clk), .baud_tick(baud_tick), .rx_in(rx_in));

  // ****************************************************************
  // clock, baud tick and hang guard
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    baud_tick <= #1 ~baud_tick;
    if (cyc == LIMIT) begin
      errors++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // bus and serial helpers
  // ****************************************************************
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    #1;
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = wd;
    @(posedge clk);
    #1;
    penable = 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    #1;
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, exp)
  endtask : chk_rd

  task automatic set_lc(input logic [7:0] v);
    lc = v;
    apb(1'b1, `UER_OFS_LCTRL, {24'h00_0000, v});
  endtask : set_lc

  task automatic send(input logic [7:0] d, input logic bad,
                      input logic stop_ok);
    logic pb;
    pb = lc[7] ? ~lc[2] : (lc[2] ? ^d : ~(^d));
    u_tx.send_frame(d, lc[1], pb ^ bad, stop_ok);
  endtask : send

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    baud_tick = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    lc = 8'h00;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    chk_rd(`UER_OFS_STATUS, 32'h0000_0000);
    chk_rd(12'h008, 32'h0000_0000);
    `CHK(err, 1'b1)
    done("reset");

    set_lc(8'h10);
    send(8'hA5, 1'b0, 1'b1);
    // frozen: no capture, no pop, prdata keeps the unmapped read
    ce = 1'b0;
    chk_rd(`UER_OFS_DATA, 32'h0000_0000);
    ce = 1'b1;
    chk_rd(`UER_OFS_DATA, 32'h0000_00A5);
    apb(1'b1, `UER_OFS_DATA, 32'hFFFF_FFC3);
    `CHK(tx_push, 1'b1)
    `CHK(tx_data, 8'hC3)
    done("data");

    // even, odd, stick 0 and stick 1 parity
    for (int m = 0; m < 4; m++) begin
      set_lc(MODES[m]);
      da = 8'h5A + 8'(m);
      send(da, 1'b0, 1'b1);
      send(~da, 1'b1, 1'b1);
      chk_rd(`UER_OFS_STATUS, 32'h0000_0000);
      chk_rd(`UER_OFS_DATA, {24'h00_0000, da});
      chk_rd(`UER_OFS_DATA, {20'h0_0000, 4'h2, ~da});
      chk_rd(`UER_OFS_STATUS, 32'h0000_0002);
      apb(1'b1, `UER_OFS_STATUS, 32'(m));
      chk_rd(`UER_OFS_STATUS, 32'h0000_0000);
    end
    done("parity");

    set_lc(8'h10);
    send(8'h3C, 1'b0, 1'b0);
    chk_rd(`UER_OFS_DATA, 32'h0000_013C);
    chk_rd(`UER_OFS_STATUS, 32'h0000_0001);
    u_tx.hold_low(25);
    send(8'h5A, 1'b0, 1'b1);
    chk_rd(`UER_OFS_DATA, 32'h0000_0500);
    chk_rd(`UER_OFS_STATUS, 32'h0000_0005);
    chk_rd(`UER_OFS_DATA, 32'h0000_005A);
    chk_rd(`UER_OFS_STATUS, 32'h0000_0000);
    done("framing_break");

    // fill the buffer past its depth, then drain it
    for (int i = 0; i < `UER_FIFO_DEPTH; i++) send(8'(i), 1'b0, 1'b1);
    send(8'hEE, 1'b0, 1'b1);
    chk_rd(`UER_OFS_STATUS, 32'h0000_0008);
    for (int i = 0; i < `UER_FIFO_DEPTH; i++) begin
      chk_rd(`UER_OFS_DATA, {20'h0_0000, i == 0, 3'h0, 8'(i)});
    end
    send(8'h77, 1'b0, 1'b1);
    chk_rd(`UER_OFS_DATA, 32'h0000_0077);
    chk_rd(`UER_OFS_STATUS, 32'h0000_0008);
    apb(1'b1, `UER_OFS_STATUS, 32'hDEAD_BEEF);
    chk_rd(`UER_OFS_STATUS, 32'h0000_0000);
    done("overrun_fifo");

    // holding register mode: depth of one
    set_lc(8'h00);
    send(8'h11, 1'b0, 1'b1);
    send(8'h22, 1'b0, 1'b1);
    chk_rd(`UER_OFS_DATA, 32'h0000_0811);
    send(8'h33, 1'b0, 1'b1);
    chk_rd(`UER_OFS_DATA, 32'h0000_0033);
    chk_rd(`UER_OFS_STATUS, 32'h0000_0008);
    done("overrun_single");
    report_and_stop();
  end
endmodule : tb_uer_rx_error_status
